// >>> rx_source.sv
`timescale 1ns/100ps
// ==========================================================
// receive path model: plays one queued frame byte by byte
module rx_source (
   input wire logic clk_i,
   output logic rx_valid_o,
   output logic [7:0] rx_data_o,
   output logic rx_first_o,
   output logic rx_last_o
);
   logic [7:0] frm[$];
   int gap;
   // idle state at time zero
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      rx_first_o = 1'b0;
      rx_last_o = 1'b0;
      gap = 0;
   end
   // gaps toggle the data so a stale byte never looks valid
   task automatic send();
      int i;
      int g;
      for (i = 0; i < frm.size(); i++) begin
         for (g = 0; g < gap; g++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            rx_data_o <= ~rx_data_o;
         end
         @(posedge clk_i);
         rx_valid_o <= 1'b1;
         rx_data_o <= frm[i];
         rx_first_o <= (i == 0);
         rx_last_o <= (i == frm.size() - 1);
      end
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_first_o <= 1'b0;
      rx_last_o <= 1'b0;
      rx_data_o <= ~frm[frm.size() - 1];
   endtask
endmodule // rx_source

// >>> wake_pattern_detector.sv
`timescale 1ns/100ps
module wake_pattern_detector (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_first_i,
   input wire logic rx_last_i,
   output logic rx_suspend_o,
   output logic irq_o,
   output logic power_event_o
);
   // ==========================================================
   // helpers
   // byte-lane merge for wishbone writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // one byte into the crc, msb first
   function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int k = 7; k >= 0; k--) begin
         if (r[15] ^ d[k]) begin
            r = {r[14:0], 1'b0} ^ wake_pkg::CRC_POLY;
         end else begin
            r = {r[14:0], 1'b0};
         end
      end
      return r;
   endfunction

   // ==========================================================
   // wishbone slave
   logic [wake_pkg::CTRL_W-1:0] ctrl;
   logic [wake_pkg::STAT_W-1:0] status;
   logic [wake_pkg::STAT_W-1:0] int_mask;
   logic [31:0] port_word [wake_pkg::PORT_WORDS];
   logic [2:0] port_ptr;
   logic [31:0] addr_lo;
   logic [15:0] addr_hi;
   logic bus_req;
   logic bus_wr;
   logic [31:0] next_rdata;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i;

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_rdata : 32'h00000000;
      end
   end

   // read mux; unmapped addresses read zero and ignore writes
   always_comb begin
      next_rdata = 32'h00000000;
      case (wb_adr_i)
         wake_pkg::REG_CTRL: next_rdata[wake_pkg::CTRL_W-1:0] = ctrl;
         wake_pkg::REG_STATUS: next_rdata[wake_pkg::STAT_W-1:0] = status;
         wake_pkg::REG_MASK: next_rdata[wake_pkg::STAT_W-1:0] = int_mask;
         wake_pkg::REG_FILTER_PORT: next_rdata = port_word[port_ptr];
         wake_pkg::REG_ADDR_LO: next_rdata = addr_lo;
         wake_pkg::REG_ADDR_HI: next_rdata[15:0] = addr_hi;
         default: next_rdata = 32'h00000000;
      endcase
   end

   // control bits and interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= wake_pkg::CTRL_RESET;
         int_mask <= wake_pkg::STAT_RESET;
      end else if (bus_wr && wb_sel_i[0]) begin
         if (wb_adr_i == wake_pkg::REG_CTRL) begin
            ctrl <= wb_dat_i[wake_pkg::CTRL_W-1:0];
         end
         if (wb_adr_i == wake_pkg::REG_MASK) begin
            int_mask <= wb_dat_i[wake_pkg::STAT_W-1:0];
         end
      end
   end

   // station address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         addr_lo <= 32'h00000000;
         addr_hi <= 16'h0000;
      end else if (bus_wr) begin
         if (wb_adr_i == wake_pkg::REG_ADDR_LO) begin
            addr_lo <= lane_merge(addr_lo, wb_dat_i, wb_sel_i);
         end
         if (wb_adr_i == wake_pkg::REG_ADDR_HI) begin
            // only the two low lanes exist; the upper half is dropped by the cast
            addr_hi <= 16'(lane_merge({16'h0000, addr_hi}, wb_dat_i, wb_sel_i))
                       & wake_pkg::ADDR_HI_MASK;
         end
      end
   end

   // filter port: each write fills the next of eight words, then wraps;
   // a half-finished load leaves the pointer mid-way until reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_ptr <= 3'h0;
         for (int w = 0; w < wake_pkg::PORT_WORDS; w++) begin
            port_word[w] <= 32'h00000000;
         end
      end else if (bus_wr && wb_adr_i == wake_pkg::REG_FILTER_PORT) begin
         port_word[port_ptr] <= lane_merge(port_word[port_ptr], wb_dat_i, wb_sel_i);
         port_ptr <= port_ptr + 3'h1;
      end
   end

   // ==========================================================
   // receive byte position
   logic seq_active;
   logic frame_active;
   logic [wake_pkg::IDX_W-1:0] byte_idx;
   logic [wake_pkg::IDX_W-1:0] cur_idx;
   logic dest_mc;
   logic mc_now;

   // light sleep forces both detectors on
   assign seq_active = ctrl[wake_pkg::CTRL_SEQ_EN] | ctrl[wake_pkg::CTRL_LIGHT_SLEEP];
   assign frame_active = ctrl[wake_pkg::CTRL_FRAME_EN] | ctrl[wake_pkg::CTRL_LIGHT_SLEEP];
   assign cur_idx = rx_first_i ? '0 : byte_idx;
   assign mc_now = rx_first_i ? rx_data_i[0] : dest_mc;

   // index saturates so long frames never alias into the window
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_idx <= '0;
         dest_mc <= 1'b0;
      end else if (rx_valid_i) begin
         if (cur_idx != wake_pkg::IDX_MAX) begin
            byte_idx <= cur_idx + 9'h001;
         end
         dest_mc <= mc_now;
      end
   end

   // normal reception stands aside while any detector is armed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_suspend_o <= 1'b0;
      end else begin
         rx_suspend_o <= seq_active | frame_active;
      end
   end

   // ==========================================================
   // pattern filters
   logic [wake_pkg::CRC_W-1:0] crc_next [wake_pkg::FILTERS];
   logic [wake_pkg::CRC_W-1:0] pat_crc [wake_pkg::FILTERS];
   logic [wake_pkg::CMD_W-1:0] cmd [wake_pkg::FILTERS];
   logic [wake_pkg::FILTERS-1:0] hit;
   logic frame_hit;

   generate
      for (genvar f = 0; f < wake_pkg::FILTERS; f++) begin : g_filt
         logic [wake_pkg::CRC_W-1:0] crc;
         logic [wake_pkg::CRC_W-1:0] crc_base;
         logic [wake_pkg::IDX_W-1:0] off;
         logic [wake_pkg::IDX_W-1:0] rel;
         logic in_win;

         assign cmd[f] = port_word[wake_pkg::PORT_CMD_WORD][wake_pkg::CMD_STRIDE*f +: wake_pkg::CMD_W];
         assign off = {1'b0, port_word[wake_pkg::PORT_OFF_WORD][wake_pkg::OFF_W*f +: wake_pkg::OFF_W]};
         assign pat_crc[f] = port_word[wake_pkg::PORT_CRC_WORD + f/2][wake_pkg::CRC_W*(f%2) +: wake_pkg::CRC_W];
         assign rel = cur_idx - off;
         // mask bit 31 is never consulted
         assign in_win = (cur_idx >= off) && (rel < wake_pkg::MASK_BITS)
                         && port_word[f][rel[4:0]];
         assign crc_base = rx_first_i ? wake_pkg::CRC_INIT : crc;
         assign crc_next[f] = in_win ? crc16_byte(crc_base, rx_data_i) : crc_base;

         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               crc <= wake_pkg::CRC_INIT;
            end else if (rx_valid_i) begin
               crc <= crc_next[f];
            end
         end

         // broadcast is a multicast destination and has no separate gate
         assign hit[f] = rx_valid_i & rx_last_i & frame_active
                         & cmd[f][wake_pkg::CMD_EN]
                         & (cmd[f][wake_pkg::CMD_MC] == mc_now)
                         & (crc_next[f] == pat_crc[f]);
      end
   endgenerate

   assign frame_hit = |hit;

   // ==========================================================
   // wake sequence scanner
   wake_pkg::seq_state_type seq_state;
   logic [2:0] sync_cnt;
   logic [2:0] addr_idx;
   logic [3:0] copy_cnt;
   logic [7:0] addr_byte;
   logic seq_found;

   always_comb begin
      case (addr_idx)
         3'h0: addr_byte = addr_lo[7:0];
         3'h1: addr_byte = addr_lo[15:8];
         3'h2: addr_byte = addr_lo[23:16];
         3'h3: addr_byte = addr_lo[31:24];
         3'h4: addr_byte = addr_hi[7:0];
         default: addr_byte = addr_hi[15:8];
      endcase
   end

   // found on the last byte of the sixteenth copy, wherever it sits;
   // the first byte of a new frame can never finish a run left from the last one
   assign seq_found = rx_valid_i & seq_active & (seq_state == wake_pkg::SEQ_ADDR)
                      & (rx_data_i == addr_byte) & (addr_idx == wake_pkg::ADDR_LAST_BYTE)
                      & (copy_cnt == wake_pkg::ADDR_LAST_COPY) & ~rx_first_i;

   // a new frame or any mismatch restarts the hunt for the sync run
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_state <= wake_pkg::SEQ_SYNC;
         sync_cnt <= 3'h0;
         addr_idx <= 3'h0;
         copy_cnt <= 4'h0;
      end else if (rx_valid_i) begin
         case (seq_state)
            wake_pkg::SEQ_SYNC: begin
               addr_idx <= 3'h1;
               copy_cnt <= 4'h0;
               if (rx_data_i == wake_pkg::SYNC_BYTE) begin
                  if (sync_cnt != wake_pkg::SYNC_LEN || rx_first_i) begin
                     sync_cnt <= rx_first_i ? 3'h1 : sync_cnt + 3'h1;
                  end
               end else if (sync_cnt == wake_pkg::SYNC_LEN && !rx_first_i
                            && rx_data_i == addr_lo[7:0]) begin
                  seq_state <= wake_pkg::SEQ_ADDR;
               end else begin
                  sync_cnt <= 3'h0;
               end
            end
            wake_pkg::SEQ_ADDR: begin
               if (rx_first_i || rx_data_i != addr_byte || seq_found) begin
                  seq_state <= wake_pkg::SEQ_SYNC;
                  sync_cnt <= (rx_data_i == wake_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                  addr_idx <= 3'h0;
               end else if (addr_idx == wake_pkg::ADDR_LAST_BYTE) begin
                  addr_idx <= 3'h0;
                  copy_cnt <= copy_cnt + 4'h1;
               end else begin
                  addr_idx <= addr_idx + 3'h1;
               end
            end
            default: begin
               seq_state <= wake_pkg::SEQ_SYNC;
               sync_cnt <= 3'h0;
            end
         endcase
      end
   end

   // ==========================================================
   // status, interrupt and power event
   logic [wake_pkg::STAT_W-1:0] stat_set;
   logic [wake_pkg::STAT_W-1:0] stat_clr;
   logic [wake_pkg::STAT_W-1:0] pme_sel;

   assign stat_set = {frame_hit, seq_found};
   assign stat_clr = (bus_wr && wb_sel_i[0] && wb_adr_i == wake_pkg::REG_STATUS)
                     ? wb_dat_i[wake_pkg::STAT_W-1:0] : wake_pkg::STAT_RESET;
   assign pme_sel = {ctrl[wake_pkg::CTRL_PME_FRAME], ctrl[wake_pkg::CTRL_PME_SEQ]};

   // write one to clear; a same-cycle event wins over the clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status <= wake_pkg::STAT_RESET;
      end else begin
         status <= (status & ~stat_clr) | stat_set;
      end
   end

   // either path may carry the report, chosen by mask and pme bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         power_event_o <= 1'b0;
      end else begin
         irq_o <= |(status & int_mask);
         power_event_o <= |(status & pme_sel);
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_seq_flag;
      status[wake_pkg::STAT_SEQ] && int_mask[wake_pkg::STAT_SEQ];
   endsequence

   sequence s_irq_up;
      ##1 irq_o;
   endsequence

   sequence s_ack_drop;
      ##1 !wb_ack_o;
   endsequence

   filter_enable_a: assert property (hit[0] |-> cmd[0][wake_pkg::CMD_EN] && frame_active)
      else $error("disabled filter flagged a frame");
   filter_type_a: assert property (hit[1] |-> cmd[1][wake_pkg::CMD_MC] == mc_now)
      else $error("filter matched wrong address type");
   filter_crc_a: assert property (hit[2] |-> crc_next[2] == pat_crc[2])
      else $error("filter hit without crc equality");
   seq_flag_a: assert property (seq_found |=> status[wake_pkg::STAT_SEQ])
      else $error("sequence flag not set");
   frame_flag_a: assert property (frame_hit |=> status[wake_pkg::STAT_FRAME])
      else $error("frame flag not set");
   seq_irq_a: assert property (s_seq_flag |-> s_irq_up)
      else $error("interrupt not raised for sequence");
   seq_pme_a: assert property (status[wake_pkg::STAT_SEQ] && ctrl[wake_pkg::CTRL_PME_SEQ]
                               |=> power_event_o)
      else $error("power event not raised");
   suspend_on_a: assert property ($rose(ctrl[wake_pkg::CTRL_SEQ_EN]) |=> rx_suspend_o)
      else $error("reception not suspended");
   suspend_off_a: assert property ($fell(seq_active) && !frame_active |=> !rx_suspend_o)
      else $error("normal reception not restored");
   sleep_force_a: assert property (ctrl[wake_pkg::CTRL_LIGHT_SLEEP]
                                   |-> seq_active && frame_active)
      else $error("light sleep left a detector off");
   full_power_a: assert property (!seq_active |-> !seq_found)
      else $error("sequence found while disabled");
   seq_count_a: assert property (seq_found |-> copy_cnt == wake_pkg::ADDR_LAST_COPY
                                 && addr_idx == wake_pkg::ADDR_LAST_BYTE)
      else $error("sequence found before sixteen copies");
   sync_run_a: assert property (rx_valid_i && seq_state == wake_pkg::SEQ_SYNC
                                && sync_cnt != wake_pkg::SYNC_LEN
                                && rx_data_i != wake_pkg::SYNC_BYTE
                                |=> seq_state == wake_pkg::SEQ_SYNC)
      else $error("address hunt began without six sync bytes");
   new_frame_a: assert property (rx_valid_i && rx_first_i |-> !seq_found)
      else $error("sequence completed by a frame start");

   // ack follows a taken request by one edge and never stands two cycles
   ack_timing_a: assert property (bus_req |=> wb_ack_o)
      else $error("bus request not acknowledged");
   ack_single_a: assert property (wb_ack_o |-> s_ack_drop)
      else $error("acknowledge stood longer than one cycle");

   // a clear with no event in the same cycle must take the flag down
   frame_clear_a: assert property (stat_clr[wake_pkg::STAT_FRAME] && !frame_hit
                                   |=> !status[wake_pkg::STAT_FRAME])
      else $error("frame flag survived its clear");
   seq_clear_a: assert property (stat_clr[wake_pkg::STAT_SEQ] && !seq_found
                                 |=> !status[wake_pkg::STAT_SEQ])
      else $error("sequence flag survived its clear");

   // the frame flag may also drive the power event; nothing unmasked keeps irq low
   frame_pme_a: assert property (status[wake_pkg::STAT_FRAME] && ctrl[wake_pkg::CTRL_PME_FRAME]
                                 |=> power_event_o)
      else $error("power event not raised for frame");
   irq_quiet_a: assert property (!(|(status & int_mask)) |=> !irq_o)
      else $error("interrupt raised with nothing unmasked");
endmodule // wake_pattern_detector

// >>> wake_pattern_detector_tb_top.sv
`timescale 1ns/100ps
module wake_pattern_detector_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat_w = 32'h0, wb_dat_o, rnd = 32'hcce0;
   logic wb_ack_o, rx_valid, rx_first, rx_last, rx_suspend_o, irq_o, power_event_o;
   logic [7:0] rx_data;
   logic [7:0] base[64];
   logic [7:0] fr[$];
   logic [15:0] crc;
   logic [32:0] exp_q[$];
   int error_cnt = 0, checks_done = 0, cycles = 0;
   // ==========================================================
   // clock, instances
   always #50 clk_i = ~clk_i;
   wake_pattern_detector i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_first_i(rx_first),
      .rx_last_i(rx_last), .rx_suspend_o(rx_suspend_o), .irq_o(irq_o),
      .power_event_o(power_event_o));
   rx_source i_src (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
      .rx_first_o(rx_first), .rx_last_o(rx_last));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // msb-first crc-16, init all ones, no final xor
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic fb;
      for (int i = 7; i >= 0; i--) begin
         fb = c[15] ^ b[i];
         c = {c[14:0], 1'b0};
         if (fb) c ^= 16'h8005;
      end
      return c;
   endfunction
   task automatic check(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard: the whole run needs a few thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   // monitor: every ack retires the oldest note
   always @(posedge clk_i) begin
      logic [32:0] n;
      if (wb_ack_o === 1'b1) begin
         n = exp_q.size() ? exp_q.pop_front() : 33'h1DEADBEEF;
         if (n[32]) check(n[31:0], wb_dat_o);
      end
   end
   // one classic cycle; held until ack is seen at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic c, input logic [31:0] e);
      int n;
      exp_q.push_back({c, e});
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, dat_w} <= {2'b11, w, a, 4'hF, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) error_cnt++;
      {cyc, stb, we} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 1'b0, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 1'b1, e);
   endtask
   // frame from the random base, first byte set, at most one byte flipped
   task automatic send_base(input logic [7:0] b0, input int flip);
      fr.delete();
      for (int i = 0; i < 64; i++) fr.push_back(i == 0 ? b0 : base[i] ^ {7'h0, i == flip});
      i_src.frm = fr;
      i_src.gap = rnd[1:0];
      i_src.send();
      repeat (3) @(posedge clk_i);
   endtask
   // sync stream then n station address copies
   task automatic send_seq(input int n);
      fr.delete();
      fr.push_back(8'h01);
      for (int i = 0; i < 13; i++) fr.push_back(base[i + 20]);
      repeat (7) fr.push_back(8'hFF);
      repeat (n) fr = {fr, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
      repeat (4) fr.push_back(8'h00);
      i_src.frm = fr;
      i_src.gap = 0;
      i_src.send();
      repeat (3) @(posedge clk_i);
   endtask
   // eight port writes: filters 0 and 1 alike but for cmd, offsets 14, bit 31 of masks zero
   task automatic load(input logic [31:0] cmd);
      wr(wake_pkg::REG_FILTER_PORT, 32'h0000_0A05);
      wr(wake_pkg::REG_FILTER_PORT, 32'h0000_0A05);
      wr(wake_pkg::REG_FILTER_PORT, 32'h0);
      wr(wake_pkg::REG_FILTER_PORT, 32'h0);
      wr(wake_pkg::REG_FILTER_PORT, cmd);
      wr(wake_pkg::REG_FILTER_PORT, 32'h0000_0E0E);
      wr(wake_pkg::REG_FILTER_PORT, {crc, crc});
      wr(wake_pkg::REG_FILTER_PORT, 32'h0);
   endtask
   task automatic done(input string s);
      $display("test %0s done", s);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 64; i++) begin
         rnd = xs(rnd);
         base[i] = rnd[7:0];
      end
      crc = 16'hFFFF;
      foreach (base[i]) if (i >= 14 && i < 45 && (32'h0000_0A05 >> (i - 14)) & 1) crc = crc_byte(crc, base[i]);
      rd(wake_pkg::REG_CTRL, 32'h0);
      rd(wake_pkg::REG_STATUS, 32'h0);
      rd(wake_pkg::REG_MASK, 32'h0);
      rd(8'h20, 32'h0);
      check(32'h0, {31'h0, rx_suspend_o});
      done("reset");
      wr(wake_pkg::REG_ADDR_LO, 32'h3322_1102);
      wr(wake_pkg::REG_ADDR_HI, 32'h0000_5544);
      load(32'h0000_0801);
      wr(wake_pkg::REG_MASK, 32'h2);
      wr(wake_pkg::REG_CTRL, 32'h2);
      rd(wake_pkg::REG_CTRL, 32'h2);
      check(32'h1, {31'h0, rx_suspend_o});
      send_base(8'h02, -1);
      rd(wake_pkg::REG_STATUS, 32'h2);
      check(32'h1, {31'h0, irq_o});
      wr(wake_pkg::REG_STATUS, 32'h2);
      rd(wake_pkg::REG_STATUS, 32'h0);
      check(32'h0, {31'h0, irq_o});
      send_base(8'h02, 15);
      rd(wake_pkg::REG_STATUS, 32'h2);
      wr(wake_pkg::REG_STATUS, 32'h2);
      send_base(8'h02, 14);
      rd(wake_pkg::REG_STATUS, 32'h0);
      done("frame_match");
      send_base(8'hFF, -1);
      rd(wake_pkg::REG_STATUS, 32'h0);
      load(32'h0000_0901);
      send_base(8'hFF, -1);
      rd(wake_pkg::REG_STATUS, 32'h2);
      wr(wake_pkg::REG_STATUS, 32'h2);
      send_base(8'h02, -1);
      rd(wake_pkg::REG_STATUS, 32'h2);
      wr(wake_pkg::REG_STATUS, 32'h2);
      done("filter_type");
      // start from normal reception so the suspend really has to rise
      wr(wake_pkg::REG_CTRL, 32'h0);
      wr(wake_pkg::REG_CTRL, 32'h9);
      // suspend follows ctrl one edge after the write lands
      @(posedge clk_i);
      check(32'h1, {31'h0, rx_suspend_o});
      send_seq(15);
      rd(wake_pkg::REG_STATUS, 32'h0);
      send_seq(16);
      rd(wake_pkg::REG_STATUS, 32'h1);
      check(32'h1, {31'h0, power_event_o});
      check(32'h0, {31'h0, irq_o});
      wr(wake_pkg::REG_STATUS, 32'h1);
      done("sequence");
      wr(wake_pkg::REG_CTRL, 32'h0);
      @(posedge clk_i);
      check(32'h0, {31'h0, rx_suspend_o});
      send_seq(16);
      rd(wake_pkg::REG_STATUS, 32'h0);
      wr(wake_pkg::REG_CTRL, 32'h4);
      @(posedge clk_i);
      check(32'h1, {31'h0, rx_suspend_o});
      send_base(8'h02, -1);
      send_seq(16);
      rd(wake_pkg::REG_STATUS, 32'h3);
      check(32'h1, {31'h0, irq_o});
      check(32'h0, {31'h0, power_event_o});
      done("power_state");
      finish_test();
   end
endmodule // wake_pattern_detector_tb_top

// >>> wake_pkg.sv
package wake_pkg;
   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_MASK = 8'h08;
   localparam logic [7:0] REG_FILTER_PORT = 8'h0C;
   localparam logic [7:0] REG_ADDR_LO = 8'h10;
   localparam logic [7:0] REG_ADDR_HI = 8'h14;
   // ==========================================================
   // control and status fields
   localparam int CTRL_SEQ_EN = 0;
   localparam int CTRL_FRAME_EN = 1;
   localparam int CTRL_LIGHT_SLEEP = 2;
   localparam int CTRL_PME_SEQ = 3;
   localparam int CTRL_PME_FRAME = 4;
   localparam int CTRL_W = 5;
   localparam int STAT_SEQ = 0;
   localparam int STAT_FRAME = 1;
   localparam int STAT_W = 2;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
   localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
   localparam logic [15:0] ADDR_HI_MASK = 16'hFFFF;
   // ==========================================================
   // filter port layout
   localparam int FILTERS = 4;
   localparam int PORT_WORDS = 8;
   localparam int PORT_CMD_WORD = 4;
   localparam int PORT_OFF_WORD = 5;
   localparam int PORT_CRC_WORD = 6;
   localparam int CMD_EN = 0;
   localparam int CMD_MC = 3;
   localparam int CMD_W = 4;
   localparam int CMD_STRIDE = 8;
   localparam int OFF_W = 8;
   localparam int CRC_W = 16;
   localparam int IDX_W = 9;
   localparam logic [IDX_W-1:0] MASK_BITS = 9'h01F;
   localparam logic [IDX_W-1:0] IDX_MAX = 9'h1FF;
   localparam logic [CRC_W-1:0] CRC_INIT = 16'hFFFF;
   localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
   // ==========================================================
   // wake sequence
   localparam logic [7:0] SYNC_BYTE = 8'hFF;
   localparam logic [2:0] SYNC_LEN = 3'h6;
   localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
   localparam logic [3:0] ADDR_LAST_COPY = 4'hF;
   typedef enum logic [1:0] {
      SEQ_SYNC = 2'b01,
      SEQ_ADDR = 2'b10
   } seq_state_type;
endpackage
